// file: ulaw_pcm_pkg.sv
// Shared constants for the serial PCM codec port
package ulaw_pcm_pkg;
	localparam int WORD_BITS = 8;
	localparam int SEG_BITS = 3;
	localparam int STEP_BITS = 4;
	localparam int MAG_BITS = 13;
	localparam int CNT_BITS = 4;
	localparam int SYNC_BITS = 3;
	// Field positions inside a coded word
	localparam int POL_POS = 7;
	localparam int SEG_MSB = 6;
	localparam int SEG_LSB = 4;
	localparam int STEP_MSB = 3;
	// Segment bases in magnitude units of 0.3065 mV
	localparam logic [12:0] SEG_BASE [8] = '{
		13'h0000, 13'h0021, 13'h0063, 13'h00E7,
		13'h01EF, 13'h03FF, 13'h081F, 13'h105F
	};
	// Step size of segment s is 1 << (s + STEP_SHIFT0)
	localparam logic [3:0] STEP_SHIFT0 = 4'h1;
	localparam logic [12:0] STEP_MAX = 13'h000F;
	localparam logic [3:0] BITS_PER_WORD = 4'h8;
	localparam logic [3:0] LAST_BIT_IDX = 4'h7;
	// Indices into the frame sync synchroniser
	localparam int TX_SYNC_IDX = 0;
	localparam int RX_SYNC_IDX = 1;
	localparam int RX_TGL_IDX = 2;
	// Frame timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int SAMPLE_PERIOD_NS = 125000;
	localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SAMPLE_SLACK = 64;
	localparam int GAP_BITS = 16;
endpackage

// file: rx_word_if.sv
// Received word hand-over between receive link and conversion logic
`timescale 1ns/1ns
`default_nettype none
interface rx_word_if;
	logic [7:0] word;
	logic tgl;
	modport src (output word, output tgl);
	modport dst (input word, input tgl);
endinterface : rx_word_if
`default_nettype wire

// file: level_sync.sv
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} sync_state_type;
	sync_state_type q_r;
	sync_state_type q_nxt;
	always_comb begin
		q_nxt.s1 = d_i;
		q_nxt.s2 = q_r.s1;
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
	assign q_o = q_r.s2;
endmodule // level_sync
`default_nettype wire

// file: rx_deserializer.sv
// Receive-side serial word capture on the receive bit clock
`timescale 1ns/1ns
`default_nettype none
module rx_deserializer
	import ulaw_pcm_pkg::*;
(
	input wire logic rx_bit_clock_i,
	input wire logic reset_n_i,
	input wire logic rx_frame_sync_i,
	input wire logic pcm_in_i,
	rx_word_if.src link
);
	typedef struct packed {
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic [7:0] word;
		logic tgl;
	} rx_state_type;
	rx_state_type q_r;
	rx_state_type q_nxt;
	always_comb begin
		q_nxt = q_r;
		if (rx_frame_sync_i) begin
			if (q_r.cnt < BITS_PER_WORD) begin
				// Sample captured into master-slave stage
				q_nxt.shreg = {q_r.shreg[6:0], pcm_in_i};
				q_nxt.cnt = q_r.cnt + 4'h1;
			end
			if (q_r.cnt == LAST_BIT_IDX) begin
				// Only eight bits taken; whole word flagged
				q_nxt.word = {q_r.shreg[6:0], pcm_in_i};
				q_nxt.tgl = ~q_r.tgl;
			end
		end else begin
			q_nxt.cnt = '0;
		end
	end
	always_ff @(posedge rx_bit_clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end
	assign link.word = q_r.word;
	assign link.tgl = q_r.tgl;

	a_rx_word_done: assert property (@(posedge rx_bit_clock_i)
		disable iff (!reset_n_i)
		rx_frame_sync_i && q_r.cnt == LAST_BIT_IDX
		|=> link.tgl != $past(link.tgl)
		&& link.word[0] == $past(pcm_in_i))
		else $error("rx word not completed on eighth bit");
	a_rx_no_ninth: assert property (@(posedge rx_bit_clock_i)
		disable iff (!reset_n_i)
		q_r.cnt == BITS_PER_WORD |=> $stable(link.tgl))
		else $error("rx took more than eight bits");
endmodule // rx_deserializer
`default_nettype wire

// file: ulaw_pcm_serial_port.sv
// Serial PCM port of a mu-law codec: framing, coding, crossings
`timescale 1ns/1ns
`default_nettype none
module ulaw_pcm_serial_port
	import ulaw_pcm_pkg::*;
#(
	parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES,
	parameter int SAMPLE_SLACK_P = SAMPLE_SLACK
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic tx_bit_clock_i,
	input wire logic tx_frame_sync_i,
	input wire logic rx_bit_clock_i,
	input wire logic rx_frame_sync_i,
	input wire logic pcm_in_i,
	input wire logic adc_positive_i,
	input wire logic [12:0] adc_mag_i,
	output logic pcm_out_o,
	output logic pcm_out_oe_o,
	output logic adc_start_o,
	output logic [7:0] tx_code_o,
	output logic dac_load_o,
	output logic dac_positive_o,
	output logic [12:0] dac_mag_o,
	output logic [7:0] rx_code_o,
	output logic frame_overdue_o
);
	typedef struct packed {
		logic tx_sync_d;
		logic rx_sync_d;
		logic rx_tgl_seen;
		logic tx_tgl;
		logic [7:0] tx_word;
		logic adc_start;
		logic rx_pending;
		logic [7:0] rx_word;
		logic dac_load;
		logic dac_pos;
		logic [12:0] dac_mag;
		logic [15:0] gap_cnt;
		logic overdue;
	} conv_state_type;

	typedef struct packed {
		logic tgl_seen;
		logic [7:0] held;
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic oe;
		logic bit_out;
	} tx_state_type;

	localparam logic [15:0] GAP_LIMIT =
		16'(SAMPLE_CYCLES_P + SAMPLE_SLACK_P);

	conv_state_type c_r;
	conv_state_type c_nxt;
	tx_state_type t_r;
	tx_state_type t_nxt;
	logic [2:0] sync_s;
	logic tx_tgl_s;
	logic tx_rise;

	rx_word_if rx_link ();

	// Frame syncs and receive toggle brought onto the conversion clock
	level_sync #(
		.WIDTH(SYNC_BITS)
	) u_conv_sync (
		.clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.d_i({rx_link.tgl, rx_frame_sync_i, tx_frame_sync_i}),
		.q_o(sync_s)
	);

	// Transmit word toggle brought onto the transmit bit clock
	level_sync #(
		.WIDTH(1)
	) u_tx_sync (
		.clk_i(tx_bit_clock_i),
		.reset_n_i(reset_n_i),
		.d_i(c_r.tx_tgl),
		.q_o(tx_tgl_s)
	);

	rx_deserializer u_rx (
		.rx_bit_clock_i(rx_bit_clock_i),
		.reset_n_i(reset_n_i),
		.rx_frame_sync_i(rx_frame_sync_i),
		.pcm_in_i(pcm_in_i),
		.link(rx_link.src)
	);

	// Linear magnitude to sign, segment, step
	function automatic logic [7:0] encode(input logic pos,
		input logic [12:0] mag);
		logic [2:0] seg;
		logic [12:0] rem;
		logic [12:0] stp;
		seg = '0;
		for (int s = 1; s < 8; s++) begin
			if (mag >= SEG_BASE[s]) begin
				seg = 3'(s);
			end
		end
		rem = mag - SEG_BASE[seg];
		stp = rem >> (4'(seg) + STEP_SHIFT0);
		if (stp > STEP_MAX) begin
			stp = STEP_MAX;
		end
		return {pos, seg, stp[3:0]};
	endfunction

	// Segment base plus step count times step size
	function automatic logic [12:0] decode(input logic [7:0] w);
		logic [2:0] seg;
		logic [12:0] stp;
		seg = w[SEG_MSB:SEG_LSB];
		stp = {9'h000, w[STEP_MSB:0]};
		return SEG_BASE[seg] + (stp << (4'(seg) + STEP_SHIFT0));
	endfunction

	assign tx_rise = sync_s[TX_SYNC_IDX] && !c_r.tx_sync_d;

	// Conversion clock domain
	always_comb begin
		c_nxt = c_r;
		c_nxt.tx_sync_d = sync_s[TX_SYNC_IDX];
		c_nxt.rx_sync_d = sync_s[RX_SYNC_IDX];
		c_nxt.adc_start = 1'b0;
		c_nxt.dac_load = 1'b0;
		// Conversion starts on the edge after the sync rise
		if (tx_rise) begin
			c_nxt.adc_start = 1'b1;
			c_nxt.tx_word = encode(adc_positive_i, adc_mag_i);
			c_nxt.tx_tgl = ~c_r.tx_tgl;
		end
		// Decode only once the receive sync is low
		if (c_r.rx_pending && !sync_s[RX_SYNC_IDX]) begin
			c_nxt.rx_pending = 1'b0;
			c_nxt.dac_load = 1'b1;
			c_nxt.dac_pos = c_r.rx_word[POL_POS];
			c_nxt.dac_mag = decode(c_r.rx_word);
		end
		// Whole received word taken on toggle; set wins over clear
		if (sync_s[RX_TGL_IDX] != c_r.rx_tgl_seen) begin
			c_nxt.rx_tgl_seen = sync_s[RX_TGL_IDX];
			c_nxt.rx_word = rx_link.word;
			c_nxt.rx_pending = 1'b1;
		end
		// Frame period watch
		if (tx_rise) begin
			c_nxt.gap_cnt = '0;
			c_nxt.overdue = 1'b0;
		end else if (c_r.gap_cnt != GAP_LIMIT) begin
			c_nxt.gap_cnt = c_r.gap_cnt + 16'h0001;
		end else begin
			c_nxt.overdue = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			c_r <= '0;
		end else begin
			c_r <= c_nxt;
		end
	end

	// Transmit bit clock domain
	always_comb begin
		t_nxt = t_r;
		if (tx_tgl_s != t_r.tgl_seen) begin
			// Word stable in the source while the toggle travels
			t_nxt.tgl_seen = tx_tgl_s;
			t_nxt.held = c_r.tx_word;
		end
		if (!tx_frame_sync_i) begin
			t_nxt.oe = 1'b0;
			t_nxt.cnt = '0;
		end else if (t_r.cnt == 4'h0) begin
			// First shift edge set by the sync rise
			t_nxt.oe = 1'b1;
			t_nxt.bit_out = t_r.held[POL_POS];
			t_nxt.shreg = {t_r.held[6:0], 1'b0};
			t_nxt.cnt = 4'h1;
		end else if (t_r.cnt < BITS_PER_WORD) begin
			t_nxt.oe = 1'b1;
			t_nxt.bit_out = t_r.shreg[7];
			t_nxt.shreg = {t_r.shreg[6:0], 1'b0};
			t_nxt.cnt = t_r.cnt + 4'h1;
		end else begin
			t_nxt.oe = 1'b1;
		end
	end

	always_ff @(posedge tx_bit_clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			t_r <= '0;
		end else begin
			t_r <= t_nxt;
		end
	end

	assign pcm_out_o = t_r.bit_out;
	assign pcm_out_oe_o = t_r.oe;
	assign adc_start_o = c_r.adc_start;
	assign tx_code_o = c_r.tx_word;
	assign dac_load_o = c_r.dac_load;
	assign dac_positive_o = c_r.dac_pos;
	assign dac_mag_o = c_r.dac_mag;
	assign rx_code_o = c_r.rx_word;
	assign frame_overdue_o = c_r.overdue;

	// Conversion clock checks
	a_adc_start_rise: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		tx_rise |=> adc_start_o && c_r.tx_tgl != $past(c_r.tx_tgl))
		else $error("conversion not started after sync rise");
	a_adc_one_pulse: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		adc_start_o |=> !adc_start_o)
		else $error("conversion start longer than one cycle");
	a_tx_polarity: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		adc_start_o |-> tx_code_o[POL_POS] == $past(adc_positive_i))
		else $error("polarity bit does not follow sign");
	a_tx_magnitude: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		adc_start_o |-> decode(tx_code_o) <= $past(adc_mag_i))
		else $error("coded magnitude exceeds sample");
	a_tx_mag_close: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		adc_start_o && tx_code_o[STEP_MSB:0] != 4'hF
		|-> $past(adc_mag_i) < decode(tx_code_o)
		+ (13'h0002 << tx_code_o[SEG_MSB:SEG_LSB]))
		else $error("coded magnitude more than one step low");
	a_tx_code_zero: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		adc_start_o && $past(adc_mag_i) == 13'h0000
		|-> tx_code_o[SEG_MSB:0] == 7'h00)
		else $error("zero sample not coded as zero");
	a_tx_word_hold: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		!adc_start_o |-> $stable(tx_code_o))
		else $error("transmit word changed without a frame");
	a_rx_word_take: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		sync_s[RX_TGL_IDX] != c_r.rx_tgl_seen
		|=> c_r.rx_pending && rx_code_o == $past(rx_link.word))
		else $error("received word not taken whole");
	a_dac_after_fall: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		dac_load_o |-> !$past(sync_s[RX_SYNC_IDX])
		&& dac_positive_o == rx_code_o[POL_POS])
		else $error("decode began while receive sync high");
	a_dac_one_pulse: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		dac_load_o |=> !dac_load_o)
		else $error("decode load longer than one cycle");
	a_dac_sign: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		dac_load_o |-> dac_positive_o
		== $past(rx_code_o[POL_POS]))
		else $error("decoded sign differs from polarity bit");
	a_dac_floor: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		dac_load_o |-> dac_mag_o
		>= SEG_BASE[$past(rx_code_o[SEG_MSB:SEG_LSB])])
		else $error("decoded magnitude below segment base");
	a_dac_zero_code: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		dac_load_o && $past(rx_code_o[SEG_MSB:0]) == 7'h00
		|-> dac_mag_o == 13'h0000)
		else $error("zero code not decoded as zero");
	a_overdue_set: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		!tx_rise && c_r.gap_cnt == GAP_LIMIT |=> frame_overdue_o)
		else $error("missing frame not flagged");
	a_overdue_hold: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		frame_overdue_o && !tx_rise |=> frame_overdue_o)
		else $error("overdue flag dropped without a frame");
	a_overdue_clear: assert property (@(posedge ref_clk_i)
		disable iff (!reset_n_i)
		tx_rise |=> !frame_overdue_o
		&& c_r.gap_cnt == 16'h0000)
		else $error("frame watch not restarted by sync rise");

	// Transmit bit clock checks
	a_tx_release: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		!tx_frame_sync_i |=> !pcm_out_oe_o)
		else $error("output driven while sync low");
	a_tx_drive: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		tx_frame_sync_i |=> pcm_out_oe_o)
		else $error("output not driven while sync high");
	a_tx_msb_first: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		tx_frame_sync_i && t_r.cnt == 4'h0
		|=> pcm_out_o == $past(t_r.held[POL_POS])
		##1 pcm_out_o == $past(t_r.held[6], 2))
		else $error("transmit bit order wrong");
	a_tx_hold_load: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		tx_tgl_s != t_r.tgl_seen
		|=> t_r.held == $past(c_r.tx_word))
		else $error("transmit word not taken whole");
	a_tx_no_ninth: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		tx_frame_sync_i && t_r.cnt == BITS_PER_WORD
		|=> $stable(pcm_out_o))
		else $error("transmit shifted more than eight bits");
	a_tx_count_cap: assert property (@(posedge tx_bit_clock_i)
		disable iff (!reset_n_i)
		t_r.cnt <= BITS_PER_WORD)
		else $error("transmit bit count out of range");
endmodule // ulaw_pcm_serial_port
`default_nettype wire

// file: pcm_highway_model.sv
// Behavioural highway controller: bit clocks, frame syncs, receive data
`timescale 1ns/1ns
`default_nettype none
module pcm_highway_model (
	output logic tx_bit_clock_o,
	output logic tx_frame_sync_o,
	output logic rx_bit_clock_o,
	output logic rx_frame_sync_o,
	output logic pcm_data_o,
	input wire logic pcm_out_i,
	input wire logic pcm_out_oe_i
);
	initial begin
		tx_bit_clock_o = 1'b0;
		tx_frame_sync_o = 1'b0;
		rx_bit_clock_o = 1'b0;
		rx_frame_sync_o = 1'b0;
		pcm_data_o = 1'b0;
	end
	// Three idle edges, hi framed edges, two closing edges
	task automatic run_frame(input logic [7:0] word, input int hi,
		output logic [7:0] got, output int bad);
		int n;
		got = 8'h00;
		bad = 0;
		for (n = 0; n < hi + 5; n++) begin
			tx_frame_sync_o = (n >= 3) && (n < hi + 3);
			rx_frame_sync_o = tx_frame_sync_o;
			if (rx_frame_sync_o && n < 11)
				pcm_data_o = word[10 - n];
			else
				pcm_data_o = ~pcm_data_o;
			#12;
			tx_bit_clock_o = 1'b1;
			rx_bit_clock_o = 1'b1;
			#12;
			if (pcm_out_oe_i !== tx_frame_sync_o)
				bad++;
			if (tx_frame_sync_o && n < 11)
				got = {got[6:0], pcm_out_oe_i ? pcm_out_i : ~pcm_out_i};
			tx_bit_clock_o = 1'b0;
			rx_bit_clock_o = 1'b0;
			#24;
		end
	endtask
endmodule // pcm_highway_model
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the serial PCM codec port
`timescale 1ns/1ns
`default_nettype none
module testbench
	import ulaw_pcm_pkg::*;
;
	localparam int SAMPLES = 200;
	localparam int SLACK = 4;
	logic ref_clk, reset_n, tx_clk, tx_sync, rx_clk, rx_sync, pcm_in;
	logic adc_positive, pcm_out, pcm_oe, adc_start, dac_load;
	logic dac_positive, overdue, have_prev;
	logic [12:0] adc_mag, dac_mag;
	logic [7:0] tx_code, rx_code, got, prev;
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	int miscompares = 0;
	int comparisons = 0;
	int seed = 32'h31bf0d45;
	int starts = 0;
	int loads = 0;
	int bad;

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	ulaw_pcm_serial_port #(.SAMPLE_CYCLES_P(SAMPLES),
		.SAMPLE_SLACK_P(SLACK)) u_dut (.ref_clk_i(ref_clk),
		.reset_n_i(reset_n), .tx_bit_clock_i(tx_clk),
		.tx_frame_sync_i(tx_sync), .rx_bit_clock_i(rx_clk),
		.rx_frame_sync_i(rx_sync), .pcm_in_i(pcm_in),
		.adc_positive_i(adc_positive), .adc_mag_i(adc_mag),
		.pcm_out_o(pcm_out), .pcm_out_oe_o(pcm_oe),
		.adc_start_o(adc_start), .tx_code_o(tx_code),
		.dac_load_o(dac_load), .dac_positive_o(dac_positive),
		.dac_mag_o(dac_mag), .rx_code_o(rx_code),
		.frame_overdue_o(overdue));

	pcm_highway_model u_host (.tx_bit_clock_o(tx_clk),
		.tx_frame_sync_o(tx_sync), .rx_bit_clock_o(rx_clk),
		.rx_frame_sync_o(rx_sync), .pcm_data_o(pcm_in),
		.pcm_out_i(pcm_out), .pcm_out_oe_i(pcm_oe));

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen,
				want);
		end
	endtask

	task automatic conclude();
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic logic [7:0] enc(input logic p, input logic [12:0] m);
		int s;
		int st;
		s = 0;
		for (int i = 1; i < 8; i++)
			if (m >= SEG_BASE[i])
				s = i;
		st = (int'(m) - int'(SEG_BASE[s])) >> (s + 1);
		if (st > 15)
			st = 15;
		return {p, 3'(s), 4'(st)};
	endfunction

	function automatic logic [13:0] dec(input logic [7:0] w);
		int m;
		m = int'(SEG_BASE[w[6:4]]) + (int'(w[3:0]) << (w[6:4] + 1));
		return {w[7], m[12:0]};
	endfunction

	always @(negedge ref_clk) begin
		if (adc_start === 1'b1) begin
			starts++;
			check(16'(tx_code), 16'(tx_q.pop_front()));
		end
		if (dac_load === 1'b1) begin
			loads++;
			check(16'({dac_positive, dac_mag}), 16'(dec(rx_q[0])));
			check(16'(rx_code), 16'(rx_q.pop_front()));
		end
	end

	task automatic frame(input int hi, input logic [7:0] rxw,
		input logic [12:0] mag);
		logic [7:0] code;
		@(posedge ref_clk);
		#1;
		adc_positive = 1'($random(seed));
		adc_mag = mag;
		code = enc(adc_positive, mag);
		tx_q.push_back(code);
		rx_q.push_back(rxw);
		// Random phase of the link clock against the conversion clock
		#($unsigned($random(seed)) % 7);
		u_host.run_frame(rxw, hi, got, bad);
		check(16'(bad), 16'h0000);
		if (have_prev)
			check(16'(got), 16'(prev));
		prev = code;
		have_prev = 1'b1;
		repeat (100) @(posedge ref_clk);
	endtask

	initial begin
		reset_n = 1'b0;
		adc_positive = 1'b0;
		adc_mag = 13'h0000;
		have_prev = 1'b0;
		prev = 8'h00;
		repeat (4) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		repeat (4) @(posedge ref_clk);
		for (int k = 0; k < 16; k++) begin
			if (k < 8)
				frame(8, {k[0], 3'(k), 4'(k * 2)}, SEG_BASE[k]);
			else if (k == 8)
				frame(8, 8'hFF, 13'h1FFF);
			else
				frame((k == 10) ? 9 : 8, 8'($random(seed)),
					13'($random(seed)));
		end
		#1;
		check(16'(overdue), 16'h0000);
		repeat (SAMPLES + SLACK + 40) @(posedge ref_clk);
		#1;
		check(16'(overdue), 16'h0001);
		frame(8, 8'h5A, 13'h0100);
		#1;
		check(16'(overdue), 16'h0000);
		check(16'(starts), 16'h0011);
		check(16'(loads), 16'h0011);
		conclude();
	end

	initial begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule // testbench
`default_nettype wire
